// *** bth_termination_handler.sv ***
/*
 Termination handler of a transparent bridge: one posted write slot and
 one delayed transaction slot, a target-bus attempt engine that classifies
 the far target's termination, the answers given to the originating
 initiator, and an AHB-Lite register file for enables and status flags.
 Assumes the target-bus signals are sampled on hclk (bus clock) and that
 data movement, master abort and lock live in neighbouring blocks.
*/
// Functional notes
// (RULE1) Retry: stop and devsel without trdy in first data phase, no data.
// (RULE2) Abort: stop without devsel after devsel was seen earlier.
// (RULE3) Retried posted write reissues with the identical start address.
// (RULE4) Leftover posted data after retry/disconnect starts a new write.
// (RULE5) After disconnect the next write starts at the next Dword.
// (RULE6) Partly delivered invalidate-write finishes as plain memory write.
// (RULE7) Posted write abort: received-abort flag, system error, its flag.
// (RULE8) Posted write undelivered after 2^24 attempts is discarded.
// (RULE9) Delayed read: non-prefetchable disconnects at first data phase.
// (RULE10) Retried delayed read is re-initiated to the target.
// (RULE11) Disconnected delayed read: disconnect only if more data asked.
// (RULE12) Delayed read abort returns abort and sets both abort flags.
// (RULE13) Delayed read repeats until data, abort or attempt limit.
// (RULE14) Limit reached: drop request, system error, abort next attempt.
// (RULE15) Delayed write is retried while queued, pending or duplicate.
// (RULE16) Delayed read retried while queued, unready, behind writes.
// (RULE17) Posted write retried without room for address plus 8 Dwords.
// (RULE18) Initiator repeats retried delayed request identically in time.
// (RULE19) Unrepeated delayed transaction is discarded at master timeout.
// (RULE20) Disconnect at boundary, write buffer full or read data end.
// (RULE21) Target abort when forwarding one or after attempt limit.
// (RULE22) Own target abort sets signaled-abort flag on initiator side.
// (RULE23) Each slot keeps a 25-bit attempt counter, cleared on queueing.
`timescale 1ns/1ps
`include "bth_defines.svh"

module bth_termination_handler
   import bth_pkg::*;
#(
   parameter logic [24:0] ATTEMPT_LIMIT = `BTH_ATTEMPT_LIMIT
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ini_req,
   input  wire logic [1:0]  ini_kind,
   input  wire logic [31:0] ini_addr,
   input  wire logic [3:0]  ini_cmd,
   input  wire logic [7:0]  ini_count,
   input  wire logic        ini_pref,
   input  wire logic        ini_boundary,
   input  wire logic        ini_discarding,
   input  wire logic        ini_master_timeout,
   input  wire logic [7:0]  pw_free,
   output logic             ini_resp_valid,
   output logic [1:0]       ini_resp,
   output logic [7:0]       ini_xfer_count,
   output logic             tb_start,
   output logic [31:0]      tb_addr,
   output logic [3:0]       tb_cmd,
   output logic [7:0]       tb_count,
   input  wire logic        tb_frame_n,
   input  wire logic        tb_irdy_n,
   input  wire logic        tb_trdy_n,
   input  wire logic        tb_devsel_n,
   input  wire logic        tb_stop_n,
   input  wire logic        tb_mabort,
   output logic             primary_sys_error_out
);

   // -------------------------------------------------------------------
   // Register file over AHB-Lite, zero wait states
   // -------------------------------------------------------------------
   logic [2:0]  ctrl;
   logic [2:0]  status;
   logic        wr_pend;
   logic [7:0]  wr_ofs;
   logic [24:0] pw_tries;
   logic [24:0] dt_tries;
   logic [2:0]  stat_set;

   wire        in_range  = (haddr[31:8] == 24'h00_0000);
   wire        ahb_take  = hsel & htrans[1] & hready;
   wire        ahb_rd    = ahb_take & ~hwrite;
   wire        ctrl_wr   = wr_pend & (wr_ofs == `BTH_CTRL_OFS);
   wire        stat_wr   = wr_pend & (wr_ofs == `BTH_STAT_OFS);
   wire [7:0]  rd_ofs    = haddr[7:0];
   wire [31:0] rd_mux    =
      ~in_range                   ? 32'h0000_0000 :
      (rd_ofs == `BTH_CTRL_OFS)   ? {29'h0000_0000, ctrl} :
      (rd_ofs == `BTH_STAT_OFS)   ? {29'h0000_0000, status} :
      (rd_ofs == `BTH_PWTRY_OFS)  ? {7'h00, pw_tries} :
      (rd_ofs == `BTH_DTTRY_OFS)  ? {7'h00, dt_tries} :
                                    32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_ofs  <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end else begin
         wr_pend <= ahb_take & hwrite & in_range;
         wr_ofs  <= ahb_take ? haddr[7:0] : wr_ofs;
         hrdata  <= ahb_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // Status bits clear by writing one; a set in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl   <= `BTH_CTRL_RST;
         status <= `BTH_STAT_RST;
      end else begin
         if (ctrl_wr)
            ctrl <= hwdata[2:0];
         status <= (status & ~(stat_wr ? hwdata[2:0] : 3'h0)) | stat_set;
      end
   end

   // -------------------------------------------------------------------
   // Target-bus termination classification
   // -------------------------------------------------------------------
   bth_eng_t    eng;
   logic        eng_pw;
   logic [7:0]  eng_xfers;
   logic        devsel_seen;

   wire run     = (eng == ENG_RUN);
   wire xfer    = run & ~tb_irdy_n & ~tb_trdy_n & ~tb_devsel_n;
   wire stop    = run & ~tb_stop_n;
   wire t_retry = stop & ~tb_devsel_n & tb_trdy_n & (eng_xfers == 8'h00);   // [RULE1]
   wire t_abort = stop & tb_devsel_n & devsel_seen;                          // [RULE2]
   wire t_disc  = stop & ~tb_devsel_n & ~t_retry;
   wire t_norm  = run & tb_stop_n & tb_frame_n & xfer;
   wire t_mab   = run & tb_mabort;
   wire t_end   = t_retry | t_abort | t_disc | t_norm | t_mab;
   wire [7:0] xfers_all = eng_xfers + {7'h00, xfer};

   // -------------------------------------------------------------------
   // Slot state and attempt bookkeeping
   // -------------------------------------------------------------------
   logic        pw_valid;
   logic [31:0] pw_addr;
   logic [3:0]  pw_cmd;
   logic [7:0]  pw_left;
   bth_dt_t     dt_state;
   bth_kind_t   dt_kind;
   logic [31:0] dt_addr;
   logic [3:0]  dt_cmd;
   logic [7:0]  dt_count;
   logic        dt_pref;
   logic [7:0]  dt_fetched;

   wire        start_pw   = (eng == ENG_IDLE) & pw_valid;
   wire        start_dt   = (eng == ENG_IDLE) & ~pw_valid & (dt_state == DT_QUEUED);
   wire        pw_end     = t_end & eng_pw;
   wire        dt_end     = t_end & ~eng_pw;
   wire [7:0]  pw_left_nx = pw_left - {7'h00, xfer};
   wire [24:0] pw_tries_nx = pw_tries + 25'h000_0001;
   wire [24:0] dt_tries_nx = dt_tries + 25'h000_0001;
   wire        pw_unfin   = pw_end & ~t_abort & ~t_mab & (pw_left_nx != 8'h00);  // [RULE4]
   wire        pw_limit   = pw_unfin & (pw_tries_nx == ATTEMPT_LIMIT);            // [RULE8]
   wire        pw_clear   = pw_end & ~(pw_unfin & ~pw_limit);
   wire        dt_retry   = dt_end & t_retry;                                      // [RULE10]
   wire        dt_got     = dt_end & ~t_abort & ~t_mab & (xfers_all != 8'h00);   // [RULE13]
   wire        dt_limit   = dt_retry & (dt_tries_nx == ATTEMPT_LIMIT);            // [RULE14]
   wire        ctrl_en    = ctrl[`BTH_CTRL_SERR_EN];
   wire        serr_evt   = (pw_end & t_abort & ctrl_en) |                        // [RULE7]
                            (pw_limit & ctrl_en & ~ctrl[`BTH_CTRL_DIS_PW]) |      // [RULE8]
                            (dt_limit & ctrl_en & ~ctrl[`BTH_CTRL_DIS_DT]);       // [RULE14]

   // -------------------------------------------------------------------
   // Initiator-side answer
   // -------------------------------------------------------------------
   bth_resp_t   next_resp;
   logic [7:0]  next_cnt;
   logic        next_load_pw;
   logic        next_load_dt;
   logic        next_take_dt;

   // Matching needs identical address, command and kind on every repeat
   wire dt_match = (dt_state != DT_EMPTY) & (ini_kind == dt_kind) &
                   (ini_addr == dt_addr) & (ini_cmd == dt_cmd);                    // [RULE18]
   wire [7:0] pw_room = pw_free - 8'h01;

   always_comb begin
      next_resp    = RESP_RETRY;
      next_cnt     = 8'h00;
      next_load_pw = 1'b0;
      next_load_dt = 1'b0;
      next_take_dt = 1'b0;
      if (ini_kind == KIND_PW) begin
         if (pw_valid | (pw_free < `BTH_PW_MIN_FREE)) begin
            next_resp = RESP_RETRY;                                                // [RULE17]
         end else begin
            next_load_pw = ini_req & (ini_count != 8'h00);
            if (ini_boundary | (ini_count > pw_room)) begin
               next_resp = RESP_DISC;                                              // [RULE20]
               next_cnt  = (ini_count > pw_room) ? pw_room : ini_count;
            end else begin
               next_resp = RESP_ACCEPT;
               next_cnt  = ini_count;
            end
         end
      end else if (dt_state == DT_EMPTY) begin
         next_load_dt = ini_req;                                          // [RULE15] [RULE16]
      end else if (~dt_match | (dt_state == DT_QUEUED)) begin
         next_resp = RESP_RETRY;                                          // [RULE15] [RULE16]
      end else if (dt_state == DT_TABORT) begin
         next_resp    = RESP_ABORT;                                       // [RULE12] [RULE21]
         next_take_dt = ini_req;
      end else if ((ini_kind == KIND_DR) & (pw_valid | ini_discarding)) begin
         next_resp = RESP_RETRY;                                                   // [RULE16]
      end else begin
         next_take_dt = ini_req;
         if (ini_kind == KIND_DW) begin
            next_cnt  = 8'h01;
            next_resp = (ini_count > 8'h01) ? RESP_DISC : RESP_ACCEPT;
         end else if (~dt_pref) begin
            next_cnt  = 8'h01;
            next_resp = RESP_DISC;                                                 // [RULE9]
         end else if (ini_count > dt_fetched) begin
            next_cnt  = dt_fetched;
            next_resp = RESP_DISC;                                       // [RULE11] [RULE20]
         end else begin
            next_cnt  = ini_count;
            next_resp = ini_boundary ? RESP_DISC : RESP_ACCEPT;                    // [RULE20]
         end
      end
   end

   assign stat_set[`BTH_STAT_INI_STA] = ini_req & (next_resp == RESP_ABORT);      // [RULE22]
   assign stat_set[`BTH_STAT_TGT_RTA] = t_abort;                          // [RULE7] [RULE12]
   assign stat_set[`BTH_STAT_SSE]     = serr_evt;                                  // [RULE7]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ini_resp_valid        <= 1'b0;
         ini_resp              <= RESP_ACCEPT;
         ini_xfer_count        <= 8'h00;
         primary_sys_error_out <= 1'b0;
      end else begin
         ini_resp_valid        <= ini_req;
         ini_resp              <= ini_req ? next_resp : RESP_ACCEPT;
         ini_xfer_count        <= ini_req ? next_cnt : 8'h00;
         primary_sys_error_out <= serr_evt;
      end
   end

   // -------------------------------------------------------------------
   // Attempt engine; posted writes go first to keep write ordering
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eng         <= ENG_IDLE;
         eng_pw      <= 1'b0;
         eng_xfers   <= 8'h00;
         devsel_seen <= 1'b0;
         tb_start    <= 1'b0;
         tb_addr     <= 32'h0000_0000;
         tb_cmd      <= 4'h0;
         tb_count    <= 8'h00;
      end else begin
         tb_start <= start_pw | start_dt;
         case (eng)
            ENG_IDLE: begin
               eng_xfers   <= 8'h00;
               devsel_seen <= 1'b0;
               if (start_pw | start_dt) begin
                  eng      <= ENG_RUN;
                  eng_pw   <= start_pw;
                  tb_addr  <= start_pw ? pw_addr : dt_addr;                        // [RULE3]
                  tb_cmd   <= start_pw ? pw_cmd : dt_cmd;
                  tb_count <= start_pw ? pw_left : dt_count;
               end
            end
            ENG_RUN: begin
               eng_xfers   <= xfers_all;
               devsel_seen <= devsel_seen | ~tb_devsel_n;
               if (t_end)
                  eng <= ENG_IDLE;
            end
            default: eng <= ENG_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Posted write slot
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pw_valid <= 1'b0;
         pw_addr  <= 32'h0000_0000;
         pw_cmd   <= 4'h0;
         pw_left  <= 8'h00;
         pw_tries <= 25'h000_0000;
      end else if (next_load_pw) begin
         pw_valid <= 1'b1;
         pw_addr  <= ini_addr;
         pw_cmd   <= ini_cmd;
         pw_left  <= next_cnt;
         pw_tries <= 25'h000_0000;                                                  // [RULE23]
      end else if (eng_pw & run) begin
         if (xfer) begin
            pw_addr <= pw_addr + `BTH_DWORD_STEP;                                   // [RULE5]
            pw_left <= pw_left_nx;
         end
         if (pw_clear) begin
            pw_valid <= 1'b0;                                             // [RULE4] [RULE8]
         end else if (pw_end) begin
            pw_tries <= pw_tries_nx;                                                // [RULE23]
            if ((pw_cmd == `BTH_CMD_MWI) & (xfers_all != 8'h00))
               pw_cmd <= `BTH_CMD_MW;                                               // [RULE6]
         end
      end
   end

   // -------------------------------------------------------------------
   // Delayed transaction slot
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dt_state   <= DT_EMPTY;
         dt_kind    <= KIND_DR;
         dt_addr    <= 32'h0000_0000;
         dt_cmd     <= 4'h0;
         dt_count   <= 8'h00;
         dt_pref    <= 1'b0;
         dt_fetched <= 8'h00;
         dt_tries   <= 25'h000_0000;
      end else if (next_load_dt) begin
         dt_state   <= DT_QUEUED;
         dt_kind    <= bth_kind_t'(ini_kind);
         dt_addr    <= ini_addr;
         dt_cmd     <= ini_cmd;
         dt_count   <= (ini_kind == KIND_DW) ? 8'h01 : ini_count;
         dt_pref    <= ini_pref;
         dt_fetched <= 8'h00;
         dt_tries   <= 25'h000_0000;                                                // [RULE23]
      end else if (next_take_dt) begin
         dt_state <= DT_EMPTY;
      end else if (ini_master_timeout & (dt_state != DT_QUEUED)) begin
         dt_state <= DT_EMPTY;                                                      // [RULE19]
      end else if (dt_end) begin
         if (t_mab) begin
            dt_state <= DT_EMPTY;
         end else if (t_abort | dt_limit) begin
            dt_state <= DT_TABORT;                                      // [RULE14] [RULE21]
         end else if (dt_got) begin
            dt_state   <= DT_DONE;                                                  // [RULE13]
            dt_fetched <= xfers_all;
         end else begin
            dt_tries <= dt_tries_nx;                                      // [RULE10] [RULE23]
         end
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_pw_retry;
      pw_end & t_retry & ~pw_limit;
   endsequence
   sequence s_reissue_same;
      ##2 tb_start & (tb_addr == $past(pw_addr, 2));
   endsequence

   a_pw_retry_reissue: assert property (s_pw_retry |-> s_reissue_same)  // [RULE3]
      else $error("retried posted write not reissued at same address");
   a_disc_next_dword: assert property (                                  // [RULE5]
      (eng_pw & xfer & ~next_load_pw) |=> (pw_addr == $past(pw_addr) + 32'h0000_0004))
      else $error("posted write address did not advance one Dword");
   a_mwi_to_mw: assert property (                                        // [RULE6]
      (pw_end & t_disc & ~pw_clear & (pw_cmd == `BTH_CMD_MWI) & (xfers_all != 8'h00))
      |=> (pw_cmd == `BTH_CMD_MW))
      else $error("partial invalidate-write not demoted");
   a_pw_abort_flags: assert property (                                   // [RULE7]
      (pw_end & t_abort) |=> status[`BTH_STAT_TGT_RTA] &
      (primary_sys_error_out == $past(ctrl[`BTH_CTRL_SERR_EN])))
      else $error("posted write abort flags wrong");
   a_pw_limit_drop: assert property (                                    // [RULE8]
      pw_limit |=> ~pw_valid & (primary_sys_error_out ==
      ($past(ctrl[`BTH_CTRL_SERR_EN]) & ~$past(ctrl[`BTH_CTRL_DIS_PW]))))
      else $error("posted write not discarded at attempt limit");
   a_dr_nonpref_disc: assert property (                                  // [RULE9]
      (ini_req & (ini_kind == KIND_DR) & dt_match & (dt_state == DT_DONE) & ~dt_pref &
       ~pw_valid & ~ini_discarding)
      |=> ini_resp_valid & (ini_resp == RESP_DISC) & (ini_xfer_count == 8'h01))
      else $error("non-prefetchable read not disconnected on first phase");
   a_dt_limit_abort: assert property (dt_limit |=> (dt_state == DT_TABORT)) // [RULE14]
      else $error("delayed request not dropped at attempt limit");
   a_pw_room_retry: assert property (                                    // [RULE17]
      (ini_req & (ini_kind == KIND_PW) & (pw_free < 8'h09)) |=> (ini_resp == RESP_RETRY))
      else $error("posted write accepted without room");
   a_sig_tabort: assert property (                                       // [RULE22]
      (ini_resp_valid & (ini_resp == RESP_ABORT)) |-> status[`BTH_STAT_INI_STA])
      else $error("signaled target abort flag not set");

endmodule : bth_termination_handler

// *** bth_defines.svh ***
/*
 Constants for the bridge termination handler: register offsets, field
 positions, reset values, bus command codes, buffer room and the attempt limit.
 Assumes inclusion by the design file and the bench; definitions only.
*/
`ifndef BTH_DEFINES_SVH
`define BTH_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BTH_CTRL_OFS      8'h00
`define BTH_STAT_OFS      8'h04
`define BTH_PWTRY_OFS     8'h08
`define BTH_DTTRY_OFS     8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BTH_CTRL_SERR_EN  0
`define BTH_CTRL_DIS_PW   1
`define BTH_CTRL_DIS_DT   2
`define BTH_CTRL_RST      3'h0
`define BTH_STAT_INI_STA  0
`define BTH_STAT_TGT_RTA  1
`define BTH_STAT_SSE      2
`define BTH_STAT_RST      3'h0

// ----------------------------------------------------------------------
// Bus commands, buffer room and attempt limit
// ----------------------------------------------------------------------
`define BTH_CMD_MWI       4'hF
`define BTH_CMD_MW        4'h7
`define BTH_PW_MIN_FREE   8'h09
`define BTH_DWORD_STEP    32'h0000_0004
`define BTH_ATTEMPT_LIMIT 25'h100_0000

`endif

// *** bth_pkg.sv ***
/*
 Types shared by the bridge termination handler.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bth_pkg;
   typedef enum logic [1:0] {KIND_PW, KIND_DR, KIND_DW}                  bth_kind_t;
   typedef enum logic [1:0] {RESP_ACCEPT, RESP_RETRY, RESP_DISC, RESP_ABORT} bth_resp_t;
   typedef enum logic       {ENG_IDLE, ENG_RUN}                           bth_eng_t;
   typedef enum logic [1:0] {DT_EMPTY, DT_QUEUED, DT_DONE, DT_TABORT}     bth_dt_t;
endpackage : bth_pkg

// *** bth_far_target.sv ***
/* Far-bus target model: answers each attempt as the mode latched at start.
 Assumes the handler's clock; deasserted lines are driven high, never released. */
`timescale 1ns/1ps
module bth_far_target (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tb_start,
   input  wire logic [1:0] mode,
   output logic            tb_frame_n,
   output logic            tb_irdy_n,
   output logic            tb_trdy_n,
   output logic            tb_devsel_n,
   output logic            tb_stop_n
);
   logic [1:0] cur;
   logic [1:0] step;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step <= 2'h0;
         cur  <= 2'h0;
      end else if (tb_start) begin
         step <= 2'h1;
         cur  <= mode;
      end else if (step != 2'h0) begin
         step <= (step == 2'h3 || (step == 2'h2 && cur != 2'h2)) ? 2'h0 : step + 2'h1;
      end
   end
   // --------------------------------------------------------------
   // Mode 0 normal, 1 retry, 2 disconnect after one Dword, 3 abort
   // --------------------------------------------------------------
   wire dphase = step == 2'h2 && !cur[0];
   wire late   = step == 2'h3 && cur == 2'h2;
   assign tb_frame_n  = !(step == 2'h1 || (step == 2'h2 && cur == 2'h2));
   assign tb_irdy_n   = !(dphase || late);
   assign tb_trdy_n   = !dphase;
   assign tb_devsel_n = !(step == 2'h1 || (step == 2'h2 && cur != 2'h3) || late);
   assign tb_stop_n   = !((step == 2'h2 && cur[0]) || late);
endmodule : bth_far_target

// *** tb.sv ***
/* Self-checking bench: AHB-Lite master, initiator requests, far target.
 Assumes the attempt limit is shortened to 4 for the run. */
`timescale 1ns/1ps
`include "bth_defines.svh"
module tb;
   import bth_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ini_req, ini_pref;
   logic        ini_resp_valid, tb_start, primary_sys_error_out, zero, mto;
   logic        tb_frame_n, tb_irdy_n, tb_trdy_n, tb_devsel_n, tb_stop_n;
   logic [31:0] haddr, hwdata, hrdata, ini_addr, tb_addr, rd;
   logic [1:0]  htrans, ini_kind, ini_resp, mode;
   logic [3:0]  ini_cmd, tb_cmd;
   logic [7:0]  ini_count, pw_free, ini_xfer_count, tb_count;
   int          compares, n_mismatch, n;
   assign hready = hreadyout;
   bth_termination_handler #(.ATTEMPT_LIMIT(25'h4)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .ini_req, .ini_kind, .ini_addr, .ini_cmd, .ini_count,
      .ini_pref, .ini_boundary(zero), .ini_discarding(zero), .ini_master_timeout(mto),
      .pw_free, .ini_resp_valid, .ini_resp, .ini_xfer_count, .tb_start, .tb_addr,
      .tb_cmd, .tb_count, .tb_frame_n, .tb_irdy_n, .tb_trdy_n, .tb_devsel_n,
      .tb_stop_n, .tb_mabort(zero), .primary_sys_error_out);
   bth_far_target far (.hclk, .hresetn, .tb_start, .mode, .tb_frame_n, .tb_irdy_n,
      .tb_trdy_n, .tb_devsel_n, .tb_stop_n);
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait on handler start (0) or system error (1)
   task automatic wait_hi(input bit which);
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
      end while ((which ? primary_sys_error_out : tb_start) !== 1'b1 && n < 300);
      if (n >= 300) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : wait_hi
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   // Bounded wait for hready; running out counts as a mismatch
   task automatic wait_rdy;
      for (n = 0; n < 50; n++) begin
         @(posedge hclk);
         if (hready) break;
      end
      if (n >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : wait_rdy
   task automatic req(input logic [1:0] k, input logic [31:0] a, input logic [3:0] c,
                      input logic [7:0] cnt, input logic [1:0] exp);
      @(posedge hclk);
      ini_req   <= 1'b1;
      ini_kind  <= k;
      ini_addr  <= a;
      ini_cmd   <= c;
      ini_count <= cnt;
      @(posedge hclk);
      ini_req <= 1'b0;
      #1;
      chk({29'h0, ini_resp_valid, ini_resp}, {29'h0, 1'b1, exp});
   endtask : req
   task automatic next_mode(input logic [1:0] m);
      @(posedge hclk);
      mode <= m;
   endtask : next_mode
   task automatic t_posted;
      next_mode(2'h1);
      req(KIND_PW, 32'h1000, `BTH_CMD_MWI, 8'h02, RESP_ACCEPT);
      wait_hi(0);
      next_mode(2'h2);
      wait_hi(0);
      chk(tb_addr, 32'h1000);
      next_mode(2'h0);
      wait_hi(0);
      chk({tb_cmd, tb_addr[27:0]}, {`BTH_CMD_MW, 28'h1004});
      n = 0;
      repeat (40) begin
         @(posedge hclk);
         #1;
         n += tb_start;
      end
      chk(32'(n), 32'h0);
      pw_free <= 8'h08;
      req(KIND_PW, 32'h1200, `BTH_CMD_MW, 8'h04, RESP_RETRY);
      pw_free <= 8'h09;
      req(KIND_PW, 32'h1100, `BTH_CMD_MW, 8'h01, RESP_ACCEPT);
      wait_hi(0);
      repeat (4) @(posedge hclk);
      $display("posted write test done");
   endtask : t_posted
   task automatic t_abort;
      ahb(1'b1, `BTH_CTRL_OFS, 32'h1);
      next_mode(2'h3);
      req(KIND_PW, 32'h2000, `BTH_CMD_MW, 8'h01, RESP_ACCEPT);
      wait_hi(1);
      ahb(1'b0, `BTH_STAT_OFS, 32'h0);
      chk(rd, 32'h6);
      ahb(1'b1, `BTH_STAT_OFS, 32'h7);
      ahb(1'b0, `BTH_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, `BTH_PWTRY_OFS, 32'hFF);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      next_mode(2'h1);
      req(KIND_PW, 32'h2100, `BTH_CMD_MW, 8'h01, RESP_ACCEPT);
      wait_hi(1);
      $display("abort and register test done");
   endtask : t_abort
   task automatic t_dread;
      next_mode(2'h1);
      req(KIND_DR, 32'h3000, 4'h6, 8'h02, RESP_RETRY);
      wait_hi(0);
      next_mode(2'h0);
      wait_hi(0);
      repeat (8) @(posedge hclk);
      req(KIND_DR, 32'h3000, 4'h6, 8'h02, RESP_DISC);
      chk({24'h0, ini_xfer_count}, 32'h1);
      next_mode(2'h1);
      ini_pref <= 1'b1;
      req(KIND_DR, 32'h4000, 4'h6, 8'h01, RESP_RETRY);
      wait_hi(1);
      req(KIND_DR, 32'h4000, 4'h6, 8'h01, RESP_ABORT);
      ahb(1'b0, `BTH_STAT_OFS, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      next_mode(2'h0);
      req(KIND_DR, 32'h5000, 4'h6, 8'h01, RESP_RETRY);
      wait_hi(0);
      repeat (4) @(posedge hclk);
      mto <= 1'b1;
      @(posedge hclk);
      mto <= 1'b0;
      req(KIND_DR, 32'h5000, 4'h6, 8'h01, RESP_RETRY);
      $display("delayed read test done");
   endtask : t_dread
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, ini_req, ini_pref, zero, mto, htrans, ini_kind, mode} = '0;
      {haddr, hwdata, ini_addr, ini_cmd, ini_count} = '0;
      pw_free = 8'h20;
      compares = 0;
      n_mismatch = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `BTH_CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      t_posted();
      t_abort();
      t_dread();
      report_and_stop();
   end
endmodule : tb
